// ==== otp_status_map.svh ====
// Behaviour
// - Security area of 128 bytes: 0..63 user once, 64..127 factory fixed
// - Factory half 64..127 is never written by any command
// - User half programs without erase, all 64 bytes as one unit
// - Once the user half is programmed, later program attempts are refused
// - Program: opcode 9Bh, three address bytes, data bytes into buffer
// - Program address bits 23 down to 6 are ignored
// - On chip-select release, buffered bytes are written from start address
// - User bytes without data stay at erased value FFh
// - Programming is self-timed, finishing within the secure program time
// - Need full address, one full data byte, byte-aligned release, else abort
// - Any program abort clears the write-enable latch
// - Busy is reported in status during programming; host polls it
// - Write-enable latch clears before programming finishes
// - Program command overwrites the shared 256-byte buffer
// - Read: opcode 77h, three address bytes, two dummy bytes, then data
// - Read wraps from location 7Fh to 00h with no delay
// - Chip-select release ends a read at any bit, output goes high-Z
// - Status read is accepted at any time, also while busy
// - Opcode 05h shifts status bit 7 to 0, repeating with fresh samples
// - Chip-select release ends status read at any bit, output high-Z
// - Status bit 0 is 1 while busy, 0 when ready
// - Status bit 5 is 1 if last program left a wrong byte
// - Only status bits 7 and 2 are writable; bits 6 and 3 read 0
// - Error flag unchanged on aborted programs, updated only by run ones
// - Write-enable latch is 0 after reset; status bit follows it
`ifndef OTP_STATUS_MAP_SVH
`define OTP_STATUS_MAP_SVH
`define OP_OTP_PROGRAM     8'h9B
`define OP_OTP_READ        8'h77
`define OP_STATUS_READ     8'h05
`define OP_WRITE_ENABLE    8'h06
`define OP_WRITE_DISABLE   8'h04
`define ERASED_BYTE        8'hFF
`define USER_BYTES         7'h40
`define BIT_BUSY           0
`define BIT_WRITE_LATCH    1
`define BIT_ARRAY_PROTECT  2
`define BIT_PROTECT_PIN    4
`define BIT_OP_ERROR       5
`define BIT_PROTECT_LOCK   7
`define BITS_OPCODE_LAST   16'h0007
`define BITS_ADDR_BYTE1    16'h000F
`define BITS_ADDR_BYTE2    16'h0017
`define BITS_ADDR_BYTE3    16'h001F
`define BITS_STATUS_START  16'h0008
`define BITS_READ_HEADER   16'h0030
`define BITS_MIN_PROGRAM   8'h28
`define BUF_DEPTH          9'h100
`define PROG_TIME_US       2000
`define CLOCK_MHZ          250
`define PROG_CYCLES        (`PROG_TIME_US * `CLOCK_MHZ)
`endif

// ==== otp_status_pkg.sv ====
package otp_status_pkg;
  typedef struct packed {
    logic [7:0] opcode;
    logic       aligned;
    logic [7:0] bits;
    logic [5:0] start;
    logic [6:0] count;
  } frame_info_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PROG = 3'b010,
    ST_DONE = 3'b100
  } prog_state_t;
endpackage : otp_status_pkg

// ==== otp_and_status_command_logic.sv ====
`include "otp_status_map.svh"
module otp_and_status_command_logic
  import otp_status_pkg::*;
#(
  parameter int PROG_CYCLES = `PROG_CYCLES,
  parameter logic [511:0] FACTORY_DATA = {64{8'h5A}}
) (
  // System
  input  wire logic i_clock,
  input  wire logic i_reset_n,
  // Serial link
  input  wire logic i_sck,
  input  wire logic i_cs_n,
  input  wire logic i_si,
  output logic      o_so,
  output logic      o_so_oe,
  // Pins and status bits held elsewhere
  input  wire logic i_wp_n,
  input  wire logic i_protect_lock_bit,
  input  wire logic i_array_protect_bit,
  input  wire logic i_verify_fail,
  // Status
  output logic [7:0] o_device_status_word,
  output logic       o_ready_busy_flag
);
  // Link domain: counters and shift register on the serial clock
  logic [7:0]  shift_q;
  logic [15:0] bitcnt_q;
  logic [7:0]  op_q;
  logic [23:0] addr_q;
  logic [6:0]  rd_ptr_q;
  logic [8:0]  wcnt_q;
  logic [7:0]  buf_mem [0:255];
  logic [7:0]  so_byte_q;
  logic        frame_tgl_q;
  frame_info_t info_q;
  logic [7:0]  stat_s1_q;
  logic [7:0]  stat_s2_q;
  logic [7:0]  otp_mem [0:127];
  logic [7:0]  cur_shift;
  logic [15:0] nbits;
  logic [7:0]  sr_data;
  logic        byte_end;
  logic        byte_start;
  logic        buf_wr;
  logic        in_status;
  logic        in_read;
  logic [6:0]  rd_idx;
  logic [7:0]  rd_byte;

  // Read location: start address on the first data byte, else the pointer
  function automatic logic [6:0] read_index(input logic [15:0] bits,
                                            input logic [6:0]  start,
                                            input logic [6:0]  ptr);
    return (bits == `BITS_READ_HEADER) ? start : ptr;
  endfunction

  // User location of a buffered byte; 7 bits hold start plus count
  function automatic logic [6:0] user_loc(input logic [5:0] start,
                                          input logic [6:0] idx);
    return {1'b0, start} + idx;
  endfunction

  assign cur_shift  = {shift_q[6:0], i_si};
  assign nbits      = bitcnt_q + 16'h0001;
  assign byte_end   = (bitcnt_q[2:0] == 3'h7);
  assign byte_start = (bitcnt_q[2:0] == 3'h0);
  assign buf_wr     = (op_q == `OP_OTP_PROGRAM) && byte_end &&
                      (bitcnt_q > `BITS_ADDR_BYTE3) && (wcnt_q != `BUF_DEPTH);
  assign in_status  = (op_q == `OP_STATUS_READ) &&
                      (bitcnt_q >= `BITS_STATUS_START);
  assign in_read    = (op_q == `OP_OTP_READ) &&
                      (bitcnt_q >= `BITS_READ_HEADER);
  assign rd_idx     = read_index(bitcnt_q, addr_q[6:0], rd_ptr_q);
  assign rd_byte    = otp_mem[rd_idx];
  assign sr_data    = stat_s2_q;

  // Bits still moving at chip-select release are the frame's final state
  always_ff @(posedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      bitcnt_q <= 16'h0000;
      shift_q  <= 8'h00;
    end else begin
      bitcnt_q <= (bitcnt_q == 16'hFFFF) ? 16'hFFF8 : nbits;
      shift_q  <= cur_shift;
    end
  end

  always_ff @(posedge i_sck or negedge i_reset_n) begin
    if (!i_reset_n) begin
      op_q <= 8'h00;
    end else if (!i_cs_n && bitcnt_q == `BITS_OPCODE_LAST) begin
      op_q <= cur_shift;
    end
  end

  always_ff @(posedge i_sck or negedge i_reset_n) begin
    if (!i_reset_n) begin
      addr_q <= 24'h000000;
    end else if (!i_cs_n && (bitcnt_q == `BITS_ADDR_BYTE1 ||
                 bitcnt_q == `BITS_ADDR_BYTE2 ||
                 bitcnt_q == `BITS_ADDR_BYTE3)) begin
      addr_q <= {addr_q[15:0], cur_shift};
    end
  end

  always_ff @(posedge i_sck or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wcnt_q <= 9'h000;
    end else if (!i_cs_n) begin
      if (bitcnt_q == `BITS_OPCODE_LAST) begin
        wcnt_q <= 9'h000;
      end else if (buf_wr) begin
        wcnt_q <= wcnt_q + 9'h001;
      end
    end
  end

  // No reset on the buffer: it is only read after a fill
  always_ff @(posedge i_sck) begin
    if (!i_cs_n && buf_wr) begin
      buf_mem[wcnt_q[7:0]] <= cur_shift;
    end
  end

  // Frame summary captured on release; a short frame carries no opcode
  always_ff @(posedge i_cs_n or negedge i_reset_n) begin
    if (!i_reset_n) begin
      info_q      <= '0;
      frame_tgl_q <= 1'b0;
    end else begin
      info_q.opcode  <= (bitcnt_q > `BITS_OPCODE_LAST) ? op_q : 8'h00;
      info_q.aligned <= byte_start;
      info_q.bits    <= (bitcnt_q > 16'h00FF) ? 8'hFF : bitcnt_q[7:0];
      info_q.start   <= addr_q[5:0];
      info_q.count   <= (wcnt_q > 9'h040) ? 7'h40 : wcnt_q[6:0];
      frame_tgl_q    <= ~frame_tgl_q;
    end
  end

  // Status sampled into link domain through two flops
  always_ff @(posedge i_sck or negedge i_reset_n) begin
    if (!i_reset_n) begin
      stat_s1_q <= 8'h00;
      stat_s2_q <= 8'h00;
    end else begin
      stat_s1_q <= o_device_status_word;
      stat_s2_q <= stat_s1_q;
    end
  end

  // Enable drops at once when chip select rises, at any bit
  always_ff @(negedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      o_so_oe <= 1'b0;
    end else begin
      o_so_oe <= in_status || in_read;
    end
  end

  // Output launches on falling edge, byte chosen at each byte start
  always_ff @(negedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      o_so      <= 1'b0;
      so_byte_q <= 8'h00;
    end else if (in_status && byte_start) begin
      o_so      <= sr_data[7];
      so_byte_q <= {sr_data[6:0], 1'b0};
    end else if (in_read && byte_start) begin
      o_so      <= rd_byte[7];
      so_byte_q <= {rd_byte[6:0], 1'b0};
    end else if (in_status || in_read) begin
      o_so      <= so_byte_q[7];
      so_byte_q <= {so_byte_q[6:0], 1'b0};
    end else begin
      o_so <= 1'b0;
    end
  end

  // Pointer wraps 7Fh to 00h in its own width, with no gap
  always_ff @(negedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      rd_ptr_q <= 7'h00;
    end else if (in_read && byte_start) begin
      rd_ptr_q <= rd_idx + 7'h01;
    end
  end

  // System domain: frame event crossing via toggle
  logic [2:0]  tgl_sync_q;
  logic        frame_evt;
  logic        write_enable_latch_q;
  logic        op_error_flag_q;
  logic        otp_used_q;
  logic        wp_s1_q;
  logic        wp_s2_q;
  logic [31:0] timer_q;
  logic [6:0]  wr_idx_q;
  logic        fail_q;
  prog_state_t state_q;
  frame_info_t snap_q;
  logic        prog_ok;
  logic        prog_req;
  logic        prog_abort;
  logic        prog_start;
  logic        prog_end;
  logic        wr_go;
  logic [6:0]  wr_loc;

  // Full address plus one data byte means at least 40 bits
  assign frame_evt  = tgl_sync_q[2] ^ tgl_sync_q[1];
  assign prog_ok    = info_q.aligned &&
                      info_q.bits >= `BITS_MIN_PROGRAM;
  assign prog_req   = (state_q == ST_IDLE) && frame_evt &&
                      (info_q.opcode == `OP_OTP_PROGRAM) &&
                      write_enable_latch_q;
  assign prog_abort = prog_req && (!prog_ok || otp_used_q);
  assign prog_start = prog_req && prog_ok && !otp_used_q;
  assign wr_loc     = user_loc(snap_q.start, wr_idx_q);
  assign wr_go      = (state_q == ST_PROG) && (wr_idx_q < snap_q.count) &&
                      (wr_loc < `USER_BYTES);
  assign prog_end   = (state_q == ST_PROG) &&
                      (timer_q >= 32'(PROG_CYCLES - 2));

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tgl_sync_q <= 3'b000;
      wp_s1_q    <= 1'b1;
      wp_s2_q    <= 1'b1;
    end else begin
      tgl_sync_q <= {tgl_sync_q[1:0], frame_tgl_q};
      wp_s1_q    <= i_wp_n;
      wp_s2_q    <= wp_s1_q;
    end
  end

  // Frames arriving while busy are dropped, except status and OTP reads
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (prog_start) begin
            state_q <= ST_PROG;
          end
        end
        ST_PROG: begin
          if (prog_end) begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Latch commands need a byte-aligned release
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      write_enable_latch_q <= 1'b0;
    end else if (prog_abort || prog_end) begin
      write_enable_latch_q <= 1'b0;
    end else if (state_q == ST_IDLE && frame_evt && info_q.aligned) begin
      if (info_q.opcode == `OP_WRITE_ENABLE) begin
        write_enable_latch_q <= 1'b1;
      end else if (info_q.opcode == `OP_WRITE_DISABLE) begin
        write_enable_latch_q <= 1'b0;
      end
    end
  end

  // One program per fresh part, whatever byte count it carried
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      otp_used_q <= 1'b0;
      snap_q     <= '0;
    end else if (prog_start) begin
      otp_used_q <= 1'b1;
      snap_q     <= info_q;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      timer_q <= 32'h0;
    end else if (prog_start) begin
      timer_q <= 32'h0;
    end else if (state_q == ST_PROG) begin
      timer_q <= timer_q + 32'h1;
    end
  end

  // One buffered byte per clock, well inside the program time
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_idx_q <= 7'h00;
    end else if (prog_start) begin
      wr_idx_q <= 7'h00;
    end else if (wr_go) begin
      wr_idx_q <= wr_idx_q + 7'h01;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      fail_q <= 1'b0;
    end else if (prog_start) begin
      fail_q <= 1'b0;
    end else if (state_q == ST_PROG && i_verify_fail) begin
      fail_q <= 1'b1;
    end
  end

  // Aborted programs never reach the done state, so the flag holds
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      op_error_flag_q <= 1'b0;
    end else if (state_q == ST_DONE) begin
      op_error_flag_q <= fail_q;
    end
  end

  // Reset stands in for a fresh part; read side only sees it idle
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < 64; i++) begin
        otp_mem[i]      <= `ERASED_BYTE;
        otp_mem[i + 64] <= FACTORY_DATA[i*8 +: 8];
      end
    end else if (wr_go) begin
      otp_mem[wr_loc] <= buf_mem[8'(wr_idx_q)];
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_device_status_word <= 8'h00;
      o_ready_busy_flag    <= 1'b0;
    end else begin
      o_device_status_word[`BIT_PROTECT_LOCK]  <= i_protect_lock_bit;
      o_device_status_word[6]                  <= 1'b0;
      o_device_status_word[`BIT_OP_ERROR]      <= op_error_flag_q;
      o_device_status_word[`BIT_PROTECT_PIN]   <= wp_s2_q;
      o_device_status_word[3]                  <= 1'b0;
      o_device_status_word[`BIT_ARRAY_PROTECT] <= i_array_protect_bit;
      o_device_status_word[`BIT_WRITE_LATCH]   <= write_enable_latch_q;
      o_device_status_word[`BIT_BUSY]          <=
        (state_q != ST_IDLE);
      o_ready_busy_flag                        <= (state_q != ST_IDLE);
    end
  end
endmodule // otp_and_status_command_logic

// ==== otp_status_asserts.sv ====
module otp_status_asserts #(
  parameter int PROG_CYCLES = 800
) (
  // System
  input wire logic       i_clock,
  input wire logic       i_reset_n,
  // Link and pins
  input wire logic       i_cs_n,
  input wire logic       i_wp_n,
  input wire logic       i_protect_lock_bit,
  input wire logic       i_array_protect_bit,
  // Outputs watched
  input wire logic       o_so_oe,
  input wire logic [7:0] o_device_status_word,
  input wire logic       o_ready_busy_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  // Small margin past the program time, counted from the busy flag rise
  localparam int BUSY_MAX = PROG_CYCLES + 8;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  sequence s_busy_start;
    $rose(o_ready_busy_flag);
  endsequence
  sequence s_busy_end;
    ##[1:BUSY_MAX] !o_ready_busy_flag;
  endsequence
  property p_oe_off; i_cs_n |-> !o_so_oe; endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("serial out driven while deselected");
  property p_busy_bit; o_device_status_word[0] == o_ready_busy_flag;
  endproperty
  a_busy_bit: assert property (p_busy_bit)
    else $error("status busy bit differs from busy flag");
  property p_reserved;
    !o_device_status_word[6] && !o_device_status_word[3];
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved status bit set");
  property p_lock;
    $stable(i_protect_lock_bit)[*4]
      |-> o_device_status_word[7] == i_protect_lock_bit;
  endproperty
  a_lock: assert property (p_lock)
    else $error("lock bit not reflected");
  property p_protect;
    $stable(i_array_protect_bit)[*4]
      |-> o_device_status_word[2] == i_array_protect_bit;
  endproperty
  a_protect: assert property (p_protect)
    else $error("protect bit not reflected");
  property p_wp; $stable(i_wp_n)[*6] |-> o_device_status_word[4] == i_wp_n;
  endproperty
  a_wp: assert property (p_wp)
    else $error("protect pin state not reflected");
  property p_busy_len; s_busy_start |-> s_busy_end; endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("programming did not finish in time");
  property p_wel_done; $fell(o_ready_busy_flag) |-> !o_device_status_word[1];
  endproperty
  a_wel_done: assert property (p_wel_done)
    else $error("write enable latch still set after programming");
  property p_wel_reset; $rose(i_reset_n) |-> !o_device_status_word[1];
  endproperty
  a_wel_reset: assert property (p_wel_reset)
    else $error("write enable latch set out of reset");
endmodule // otp_status_asserts

// ==== otp_host_model.sv ====
module otp_host_model (
  // Serial link
  output logic      o_sck,
  output logic      o_cs_n,
  output logic      o_si,
  input  wire logic i_so,
  input  wire logic i_so_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rx [$];
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b0;
  end
  // Mode 0, 32 ns period; clock stands low between frames
  task automatic frame(input logic [7:0] tx [$], input int nbits);
    logic [7:0] b;
    rx.delete();
    b = 8'h00;
    #7 o_cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      // Past the bytes given, the line toggles every bit
      o_si = (i / 8 < tx.size()) ? tx[i / 8][7 - i % 8] : ~o_si;
      #16 o_sck = 1'b1;
      b = {b[6:0], i_so_oe ? i_so : 1'bx};
      if (i % 8 == 7)
        rx.push_back(b);
      #16 o_sck = 1'b0;
    end
    #16 o_cs_n = 1'b1;
    o_si = ~o_si;
  endtask
endmodule // otp_host_model

// ==== otp_and_status_command_logic_tb_top.sv ====
module otp_and_status_command_logic_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int         PC  = 800;
  localparam logic [7:0] FAC = 8'hC3;
  logic i_clock = 0, i_reset_n = 0, wp_n = 1, lock = 0, prot = 0, vfail = 0;
  logic       sck, cs_n, si, so, so_oe, busy;
  logic [7:0] st;
  logic [7:0] mem [128];
  logic [7:0] pd [$];
  int         n_mismatch = 0, comparisons = 0;
  always #2 i_clock = ~i_clock;
  otp_and_status_command_logic #(.PROG_CYCLES(PC),
    .FACTORY_DATA({64{FAC}})) uut (.i_clock(i_clock),
    .i_reset_n(i_reset_n), .i_sck(sck), .i_cs_n(cs_n), .i_si(si),
    .o_so(so), .o_so_oe(so_oe), .i_wp_n(wp_n), .i_protect_lock_bit(lock),
    .i_array_protect_bit(prot), .i_verify_fail(vfail),
    .o_device_status_word(st), .o_ready_busy_flag(busy));
  otp_host_model host (.o_sck(sck), .o_cs_n(cs_n), .o_si(si), .i_so(so),
    .i_so_oe(so_oe));
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [7:0] exp_st(logic b, logic w, logic e);
    return {lock, 1'b0, e, wp_n, 1'b0, prot, w, b};
  endfunction
  task automatic status(logic b, logic w, logic e, logic [7:0] m);
    host.frame('{8'h05}, 32);
    for (int i = 1; i < 4; i++)
      chk("status", exp_st(b, w, e) & m, host.rx[i] & m);
  endtask
  task automatic rd(logic [6:0] a, int n);
    host.frame('{8'h77, 8'h00, 8'h00, {1'b0, a}, 8'h00, 8'h00}, 48 + 8 * n);
    for (int i = 0; i < n; i++)
      chk("otp byte", mem[(a + i) % 128], host.rx[6 + i]);
  endtask
  task automatic we();
    host.frame('{8'h06}, 8);
  endtask
  // Upper address bits random: the device must not decode them
  task automatic prog(logic [5:0] s, int n, int extra, logic ok);
    pd = '{8'h9B, 8'($urandom), 8'($urandom), {2'($urandom), s}};
    repeat (n) pd.push_back(8'($urandom));
    host.frame(pd, 8 * pd.size() + extra);
    for (int i = 0; i < n; i++)
      if (ok && s + i < 64)
        mem[s + i] = pd[4 + i];
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    int r;
    r = $urandom(63);
    {lock, prot, wp_n} = 3'($urandom);
    foreach (mem[i]) mem[i] = i < 64 ? 8'hFF : FAC;
    repeat (6) @(posedge i_clock);
    #1 i_reset_n = 1'b1;
    repeat (4) @(posedge i_clock);
    status(0, 0, 0, 8'hFF);
    rd(7'h7E, 4);
    $display("test reset_and_read done");
    prog(6'h05, 3, 0, 0);
    rd(7'h00, 8);
    we();
    status(0, 1, 0, 8'hFF);
    prog(6'h00, 2, 3, 0);
    status(0, 0, 0, 8'hFF);
    rd(7'h00, 4);
    $display("test refused_programs done");
    we();
    prog(6'h3C, 6, 0, 1);
    status(1, 0, 0, 8'hFD);
    for (r = 0; r < 2000 && busy !== 1'b0; r++) @(posedge i_clock);
    chk("busy", 8'h00, {7'h00, busy});
    status(0, 0, 0, 8'hFF);
    rd(7'h00, 128);
    $display("test program_once done");
    @(posedge i_clock) #1 vfail = 1'b1;
    we();
    prog(6'h00, 4, 0, 0);
    status(0, 0, 0, 8'hFF);
    rd(7'h00, 64);
    host.frame('{8'h77}, 53);
    #4 chk("oe", 8'h00, {7'h00, so_oe});
    $display("test second_program done");
    @(posedge i_clock) #1 i_reset_n = 1'b0;
    repeat (6) @(posedge i_clock);
    #1 i_reset_n = 1'b1;
    repeat (4) @(posedge i_clock);
    foreach (mem[i]) mem[i] = i < 64 ? 8'hFF : FAC;
    we();
    prog(6'h10, 2, 0, 1);
    repeat (8) @(posedge i_clock);
    for (r = 0; r < 2000 && busy !== 1'b0; r++) @(posedge i_clock);
    status(0, 0, 1, 8'hFF);
    rd(7'h0F, 4);
    $display("test reset_and_error done");
    summarize();
  end
  initial begin
    #300us;
    n_mismatch++;
    summarize();
  end
endmodule // otp_and_status_command_logic_tb_top
bind otp_and_status_command_logic otp_status_asserts #(
  .PROG_CYCLES(PROG_CYCLES)) chk_i (.i_clock(i_clock),
  .i_reset_n(i_reset_n), .i_cs_n(i_cs_n), .i_wp_n(i_wp_n),
  .i_protect_lock_bit(i_protect_lock_bit),
  .i_array_protect_bit(i_array_protect_bit), .o_so_oe(o_so_oe),
  .o_device_status_word(o_device_status_word),
  .o_ready_busy_flag(o_ready_busy_flag));
